// [common/mad_pkg.sv]
// Package: constants and types for the memory address decode block
package mad_pkg;

	// ------------------------------------------------------------
	// Program space layout
	// ------------------------------------------------------------
	localparam int          PROG_AW          = 24;
	localparam int          PC_W             = 23;
	localparam logic [23:0] PROG_RESET_ADDR  = 24'h000000;
	localparam logic [23:0] PROG_START_SLOT  = 24'h000002;
	localparam logic [23:0] IVT_LO           = 24'h000004;
	localparam logic [23:0] IVT_HI           = 24'h0000FF;
	localparam logic [23:0] AIVT_LO          = 24'h000100;
	localparam logic [23:0] AIVT_HI          = 24'h0001FF;
	localparam logic [23:0] VECTOR_AREA_END  = 24'h000200;
	localparam logic [23:0] CFG_LO_22K       = 24'h00ABFC;
	localparam logic [23:0] CFG_LO_32K       = 24'h00FFFC;
	localparam logic [23:0] CFG_LO_44K       = 24'h0157FC;
	localparam logic [23:0] CFG_HI_OFS       = 24'h000002;
	localparam logic [22:0] PC_STEP          = 23'h000002;

	// ------------------------------------------------------------
	// Data space layout
	// ------------------------------------------------------------
	localparam int          DATA_AW          = 16;
	localparam int          DMEM_BYTES       = 8192;
	localparam logic [15:0] NEAR_LAST        = 16'h1FFF;
	localparam int          NEAR_FIELD_W     = 13;
	localparam int          VIEW_BIT         = 15;
	localparam logic [15:0] STEP_BYTE        = 16'h0001;
	localparam logic [15:0] STEP_WORD        = 16'h0002;
	localparam logic [7:0]  SIGN_ONES        = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO        = 8'h00;

	// Program memory size selection
	typedef enum logic [1:0] {
		MAD_SZ_22K = 2'h0,
		MAD_SZ_32K = 2'h1,
		MAD_SZ_44K = 2'h2
	} mad_size_t;

	// Decode states (one-hot): reset-time configuration copy, then run and trap
	typedef enum logic [3:0] {
		MAD_ST_CFG_LO = 4'h1,
		MAD_ST_CFG_HI = 4'h2,
		MAD_ST_RUN    = 4'h4,
		MAD_ST_TRAP   = 4'h8
	} mad_state_t;

	// Working-register extend operations
	typedef enum logic [1:0] {
		MAD_EXT_NONE = 2'h0,
		MAD_EXT_SIGN = 2'h1,
		MAD_EXT_ZERO = 2'h2
	} mad_ext_t;

endpackage : mad_pkg

// [core/mad_byte_ram.sv]
// Data memory built from two byte-wide halves with separate write strobes
`timescale 1ns/1ps
module mad_byte_ram
	import mad_pkg::*;
#(
	parameter int WORDS = DMEM_BYTES / 2,
	parameter int IW    = 12
) (
	input  wire logic          i_clk,      // Core clock
	input  wire logic [IW-1:0] i_rd_idx,   // Read word index
	output logic      [15:0]   o_rd_word,  // Registered read word
	input  wire logic [IW-1:0] i_wr_idx,   // Write word index
	input  wire logic [1:0]    i_wr_lane,  // Per-byte write strobes
	input  wire logic [15:0]   i_wr_word   // Write data
);

	logic [15:0] rd_r;
	logic [15:0] rd_nxt;

	// ------------------------------------------------------------
	// Byte lanes
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_lane
			logic [7:0] mem [WORDS];
			always_ff @(posedge i_clk) begin
				if (i_wr_lane[g]) begin // see RULE15
					mem[i_wr_idx] <= i_wr_word[8*g +: 8];
				end
			end
			always_comb begin
				rd_nxt[8*g +: 8] = mem[i_rd_idx];
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		rd_r <= rd_nxt;
	end

	assign o_rd_word = rd_r;

endmodule : mad_byte_ram

// [core/mad_decode.sv]
// Program and data address decode, byte steering and alignment traps
`timescale 1ns/1ps

// Overview of operation
// RULE1 - Program address holds low word even, high word odd; top byte unimplemented.
// RULE2 - Program counter points at low word, steps by two up or down.
// RULE3 - Program addresses below 000200h flagged as reserved vector area.
// RULE4 - Execution starts at 000000h; user puts jump and start address at 000002h.
// RULE5 - Primary vector table 000004h-0000FFh, alternate 000100h-0001FFh.
// RULE6 - Top two program words hold configuration, address set by memory size.
// RULE7 - Configuration words copied into configuration registers on every reset.
// RULE8 - Configuration bits are scattered into registers in a different order.
// RULE9 - Data addresses are 16-bit byte addresses, 64 Kbyte range.
// RULE10 - Bit 15 clear selects memory, set selects program viewing window.
// RULE11 - 8 Kbytes implemented; reads outside return zero.
// RULE12 - Low byte at even address, high byte at odd address.
// RULE13 - Post-increment pointer advances by 1 for bytes, 2 for words.
// RULE14 - Byte read fetches word, bit 0 selects byte onto low lane.
// RULE15 - Two byte halves share decode, separate write strobes.
// RULE16 - Word access at odd address raises address error trap.
// RULE17 - Misaligned read completes; misaligned write suppressed; then trap.
// RULE18 - Byte load into working register changes only low byte.
// RULE19 - Sign extend 8 to 16 bits; zero extend clears high byte.
// RULE20 - Near space 0000h-1FFFh reachable by 13-bit direct field.
// RULE21 - Move instruction has 16-bit direct field reaching whole space.
// RULE22 - Separate read and write address generation units.
// RULE23 - Address error status latched for the trap handler.
module mad_decode
	import mad_pkg::*;
#(
	parameter mad_size_t PROG_SIZE = MAD_SZ_44K,
	parameter int        CFG_W     = 16
) (
	input  wire logic                  i_clk,           // Core clock, 10 MHz
	input  wire logic                  i_sys_rst,       // Synchronous reset, active high
	// Program counter
	input  wire logic                  i_pc_advance,    // Step program counter this cycle
	input  wire logic                  i_pc_down,       // Step downward instead of up
	input  wire logic                  i_pc_load,       // Load jump target
	input  wire logic [PROG_AW-1:0]    i_pc_target,     // Jump target
	output logic      [PROG_AW-1:0]    o_program_counter, // Current fetch address
	output logic                       o_pc_vector_area,  // Address below user area
	output logic                       o_pc_ivt,          // Address in primary vector table
	output logic                       o_pc_aivt,         // Address in alternate vector table
	// Program memory fetch and config copy
	output logic      [PROG_AW-1:0]    o_prog_addr,     // Program fetch address
	input  wire logic [PROG_AW-1:0]    i_prog_data,     // 24-bit instruction read back
	output logic      [15:0]           o_prog_lo_word,  // Even (low) instruction word
	output logic      [15:0]           o_prog_hi_word,  // Odd (high) word, top byte zero
	output logic      [CFG_W-1:0]      o_cfg_reg_a,     // Configuration register A
	output logic      [CFG_W-1:0]      o_cfg_reg_b,     // Configuration register B
	output logic                       o_cfg_done,      // Config copy finished
	// Read address generation unit
	input  wire logic                  i_rd_req,        // Data read request
	input  wire logic                  i_rd_byte,       // Byte-size read
	input  wire logic                  i_rd_direct,     // Direct address read
	input  wire logic                  i_rd_move,       // Move instruction (16-bit field)
	input  wire logic [DATA_AW-1:0]    i_rd_direct_addr, // Direct address field
	input  wire logic                  i_rd_postinc,    // Post-increment the pointer
	input  wire logic [DATA_AW-1:0]    i_source_pointer_register, // Read pointer value
	output logic      [DATA_AW-1:0]    o_rd_effective_address,    // Read byte address
	output logic      [DATA_AW-1:0]    o_rd_pointer_nxt, // Updated read pointer
	output logic                       o_rd_view,       // Read routed to program window
	output logic      [15:0]           o_rd_data,       // Read data (byte on low lane)
	output logic                       o_rd_valid,      // Read data valid
	// Write address generation unit
	input  wire logic                  i_wr_req,        // Data write request
	input  wire logic                  i_wr_byte,       // Byte-size write
	input  wire logic [DATA_AW-1:0]    i_wr_effective_address, // Write byte address
	input  wire logic [15:0]           i_wr_data,       // Write data, byte on low lane
	input  wire logic                  i_wr_postinc,    // Post-increment the write pointer
	output logic      [DATA_AW-1:0]    o_wr_pointer_nxt, // Updated write pointer
	// Working register byte load and extend
	input  wire logic [15:0]           i_wreg_value,    // Current working register
	input  wire logic                  i_wreg_byte_load, // Byte load into working register
	input  wire logic [7:0]            i_wreg_byte,     // Byte to load
	input  wire mad_ext_t              i_ext_op,        // Extend operation
	output logic      [15:0]           o_wreg_result,   // Working register new value
	// Address error
	output logic                       o_addr_trap,     // Address error trap pulse
	output logic                       o_addr_err,      // Latched address error status
	input  wire logic                  i_addr_err_clr   // Clear address error status
);

	localparam int IW = $clog2(DMEM_BYTES) - 1;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	mad_state_t           st_r, st_nxt;
	logic [PROG_AW-1:0]   pc_r, pc_nxt;
	logic [CFG_W-1:0]     cfga_r, cfga_nxt;
	logic [CFG_W-1:0]     cfgb_r, cfgb_nxt;
	logic [15:0]          cfglo_r, cfglo_nxt;
	logic                 err_r, err_nxt;
	logic                 trap_r, trap_nxt;
	logic                 rvalid_r, rvalid_nxt;
	logic                 rzero_r, rzero_nxt;
	logic                 rsel_r, rsel_nxt;
	logic                 rbyte_r, rbyte_nxt;
	logic [15:0]          rdata_r, rdata_nxt;
	logic [15:0]          ram_word;
	logic [PROG_AW-1:0]   cfg_base;
	logic [DATA_AW-1:0]   rd_ea;
	logic                 rd_mis, wr_mis;
	logic                 rd_impl, wr_impl;
	logic [1:0]           wr_lane;
	logic [15:0]          wr_word;

	// ------------------------------------------------------------
	// Configuration word location by memory size
	// ------------------------------------------------------------
	always_comb begin
		case (PROG_SIZE) // see RULE6
			MAD_SZ_22K: cfg_base = CFG_LO_22K;
			MAD_SZ_32K: cfg_base = CFG_LO_32K;
			default:    cfg_base = CFG_LO_44K;
		endcase
	end

	// ------------------------------------------------------------
	// Program counter and reset config copy
	// ------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		pc_nxt    = pc_r;
		cfga_nxt  = cfga_r;
		cfgb_nxt  = cfgb_r;
		cfglo_nxt = cfglo_r;
		case (st_r)
			MAD_ST_CFG_LO: begin
				cfglo_nxt = i_prog_data[15:0];
				st_nxt    = MAD_ST_CFG_HI;
			end
			MAD_ST_CFG_HI: begin
				// Bits interleave across both registers on purpose
				cfga_nxt = CFG_W'({cfglo_r[7:0], i_prog_data[15:8]}); // see RULE8
				cfgb_nxt = CFG_W'({i_prog_data[7:0], cfglo_r[15:8]}); // see RULE7
				pc_nxt   = PROG_RESET_ADDR;                            // see RULE4
				st_nxt   = MAD_ST_RUN;
			end
			MAD_ST_RUN, MAD_ST_TRAP: begin
				st_nxt = MAD_ST_RUN;
				if (i_pc_load) begin
					pc_nxt = {i_pc_target[PROG_AW-1:1], 1'b0}; // see RULE2
				end else if (i_pc_advance) begin
					if (i_pc_down) begin
						pc_nxt = {1'b0, pc_r[PC_W-1:0] - PC_STEP}; // see RULE2
					end else begin
						pc_nxt = {1'b0, pc_r[PC_W-1:0] + PC_STEP};
					end
				end
			end
			default: st_nxt = MAD_ST_CFG_LO;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r    <= MAD_ST_CFG_LO; // see RULE7
			pc_r    <= PROG_RESET_ADDR;
			cfga_r  <= '0;
			cfgb_r  <= '0;
			cfglo_r <= '0;
		end else begin
			st_r    <= st_nxt;
			pc_r    <= pc_nxt;
			cfga_r  <= cfga_nxt;
			cfgb_r  <= cfgb_nxt;
			cfglo_r <= cfglo_nxt;
		end
	end

	always_comb begin
		case (st_r)
			MAD_ST_CFG_LO: o_prog_addr = cfg_base;
			MAD_ST_CFG_HI: o_prog_addr = cfg_base + CFG_HI_OFS;
			default:       o_prog_addr = pc_r;
		endcase
	end

	assign o_program_counter = pc_r;
	assign o_pc_vector_area  = (pc_r < VECTOR_AREA_END);                 // see RULE3
	assign o_pc_ivt          = (pc_r >= IVT_LO) && (pc_r <= IVT_HI);     // see RULE5
	assign o_pc_aivt         = (pc_r >= AIVT_LO) && (pc_r <= AIVT_HI);   // see RULE5
	assign o_prog_lo_word    = i_prog_data[15:0];                        // see RULE1
	assign o_prog_hi_word    = {BYTE_ZERO, i_prog_data[23:16]};          // see RULE1
	assign o_cfg_reg_a       = cfga_r;
	assign o_cfg_reg_b       = cfgb_r;
	assign o_cfg_done        = (st_r == MAD_ST_RUN) || (st_r == MAD_ST_TRAP);

	// ------------------------------------------------------------
	// Read and write address generation
	// ------------------------------------------------------------
	always_comb begin // see RULE22
		if (i_rd_direct) begin
			if (i_rd_move) begin
				rd_ea = i_rd_direct_addr; // see RULE21
			end else begin
				rd_ea = {{(DATA_AW-NEAR_FIELD_W){1'b0}}, i_rd_direct_addr[NEAR_FIELD_W-1:0]}; // see RULE20
			end
		end else begin
			rd_ea = i_source_pointer_register;
		end
	end

	assign o_rd_effective_address = rd_ea;                                            // see RULE9
	assign o_rd_pointer_nxt = i_source_pointer_register +
		(i_rd_postinc ? (i_rd_byte ? STEP_BYTE : STEP_WORD) : '0);                   // see RULE13
	assign o_wr_pointer_nxt = i_wr_effective_address +
		(i_wr_postinc ? (i_wr_byte ? STEP_BYTE : STEP_WORD) : '0);                   // see RULE13

	assign o_rd_view = i_rd_req && rd_ea[VIEW_BIT];                                   // see RULE10
	assign rd_impl   = !rd_ea[VIEW_BIT] && (rd_ea <= NEAR_LAST);                      // see RULE11
	assign wr_impl   = !i_wr_effective_address[VIEW_BIT] && (i_wr_effective_address <= NEAR_LAST);
	assign rd_mis    = i_rd_req && !i_rd_byte && rd_ea[0];                            // see RULE16
	assign wr_mis    = i_wr_req && !i_wr_byte && i_wr_effective_address[0];           // see RULE16

	// Misaligned writes never reach the array
	always_comb begin
		wr_lane = 2'h0;
		wr_word = i_wr_data;
		if (i_wr_req && wr_impl && !wr_mis) begin // see RULE17
			if (i_wr_byte) begin
				wr_lane = i_wr_effective_address[0] ? 2'h2 : 2'h1;                // see RULE15
				wr_word = {i_wr_data[7:0], i_wr_data[7:0]};                        // see RULE12
			end else begin
				wr_lane = 2'h3;
			end
		end
	end

	mad_byte_ram #(
		.WORDS (DMEM_BYTES / 2),
		.IW    (IW)
	) u_ram (
		.i_clk     (i_clk),
		.i_rd_idx  (rd_ea[IW:1]),
		.o_rd_word (ram_word),
		.i_wr_idx  (i_wr_effective_address[IW:1]),
		.i_wr_lane (wr_lane),
		.i_wr_word (wr_word)
	);

	// ------------------------------------------------------------
	// Read return, trap and error status
	// ------------------------------------------------------------
	always_comb begin
		rvalid_nxt = i_rd_req && !o_rd_view;
		rzero_nxt  = !rd_impl;
		rsel_nxt   = rd_ea[0];
		rbyte_nxt  = i_rd_byte;
		trap_nxt   = rd_mis || wr_mis; // see RULE17
		// Set wins over a simultaneous clear
		err_nxt    = (err_r && !i_addr_err_clr) || rd_mis || wr_mis; // see RULE23
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rvalid_r <= 1'b0;
			rzero_r  <= 1'b0;
			rsel_r   <= 1'b0;
			rbyte_r  <= 1'b0;
			trap_r   <= 1'b0;
			err_r    <= 1'b0;
		end else begin
			rvalid_r <= rvalid_nxt;
			rzero_r  <= rzero_nxt;
			rsel_r   <= rsel_nxt;
			rbyte_r  <= rbyte_nxt;
			trap_r   <= trap_nxt;
			err_r    <= err_nxt;
		end
	end

	always_comb begin
		if (rzero_r) begin
			rdata_nxt = '0; // see RULE11
		end else if (rbyte_r) begin
			rdata_nxt = {BYTE_ZERO, rsel_r ? ram_word[15:8] : ram_word[7:0]}; // see RULE14
		end else begin
			rdata_nxt = ram_word;
		end
	end
	assign rdata_r     = rdata_nxt;
	assign o_rd_data   = rdata_r;
	assign o_rd_valid  = rvalid_r;
	assign o_addr_trap = trap_r;
	assign o_addr_err  = err_r;

	// ------------------------------------------------------------
	// Working register byte load and extend
	// ------------------------------------------------------------
	always_comb begin
		o_wreg_result = i_wreg_value;
		if (i_wreg_byte_load) begin
			o_wreg_result = {i_wreg_value[15:8], i_wreg_byte}; // see RULE18
		end else begin
			case (i_ext_op)
				MAD_EXT_SIGN: o_wreg_result = {i_wreg_value[7] ? SIGN_ONES : BYTE_ZERO, i_wreg_value[7:0]}; // see RULE19
				MAD_EXT_ZERO: o_wreg_result = {BYTE_ZERO, i_wreg_value[7:0]}; // see RULE19
				default:      o_wreg_result = i_wreg_value;
			endcase
		end
	end

endmodule : mad_decode

// [tb/mad_decode_checker.sv]
// Assertion checker for the memory address decode block
`timescale 1ns/1ps
module mad_decode_checker
	import mad_pkg::*;
(
	input wire logic        i_clk,                  // Core clock
	input wire logic        i_sys_rst,              // Sync reset
	input wire logic        i_pc_advance,           // Step PC
	input wire logic        i_pc_down,              // Step down
	input wire logic        i_pc_load,              // Load target
	input wire logic [23:0] o_program_counter,      // PC
	input wire logic        o_pc_vector_area,       // Vector area flag
	input wire logic        o_pc_ivt,               // Primary table flag
	input wire logic [23:0] i_prog_data,            // Fetched instruction
	input wire logic [15:0] o_prog_lo_word,         // Even word
	input wire logic [15:0] o_prog_hi_word,         // Odd word
	input wire logic        o_cfg_done,             // Copy finished
	input wire logic        i_rd_req,               // Read request
	input wire logic        i_rd_byte,              // Byte read
	input wire logic [15:0] o_rd_effective_address, // Read address
	input wire logic        o_rd_view,              // Window read
	input wire logic [15:0] o_rd_data,              // Read data
	input wire logic        o_rd_valid,             // Read valid
	input wire logic        i_wr_req,               // Write request
	input wire logic        i_wr_byte,              // Byte write
	input wire logic [15:0] i_wr_effective_address, // Write address
	input wire logic        o_addr_trap,            // Trap pulse
	input wire logic        o_addr_err,             // Sticky status
	input wire logic        i_addr_err_clr          // Status clear
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	logic mis;
	assign mis = (i_rd_req && !i_rd_byte && o_rd_effective_address[0])
		|| (i_wr_req && !i_wr_byte && i_wr_effective_address[0]);

	a_pc_step: assert property (
		o_cfg_done && i_pc_advance && !i_pc_load |=> o_program_counter[22:0] == ($past(i_pc_down)
		? $past(o_program_counter[22:0]) - 23'h000002 : $past(o_program_counter[22:0]) + 23'h000002))
		else $error("program counter step wrong");
	a_vec_area: assert property (
		o_pc_vector_area == (o_program_counter < VECTOR_AREA_END)) else $error("vector area flag wrong");
	a_ivt_span: assert property (
		o_pc_ivt == (o_program_counter >= IVT_LO && o_program_counter <= IVT_HI)) else $error("table flag wrong");
	a_word_split: assert property (
		{o_prog_hi_word, o_prog_lo_word} == {8'h00, i_prog_data}) else $error("instruction word split wrong");
	a_rd_window: assert property (
		i_rd_req |-> o_rd_view == o_rd_effective_address[VIEW_BIT]) else $error("window routing wrong");
	a_rd_answer: assert property (
		i_rd_req && !o_rd_view |=> o_rd_valid) else $error("read not answered");
	a_rd_zero: assert property (
		i_rd_req && !o_rd_view && o_rd_effective_address > NEAR_LAST |=> o_rd_data == 16'h0000)
		else $error("unimplemented read not zero");
	a_trap_pulse: assert property (
		1'h1 |=> o_addr_trap == $past(mis)) else $error("trap pulse wrong");
	a_err_set: assert property (
		o_addr_trap |-> o_addr_err) else $error("status not set with trap");
	a_err_hold: assert property (
		o_addr_err && !i_addr_err_clr |=> o_addr_err) else $error("status lost");
endmodule : mad_decode_checker

bind mad_decode mad_decode_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pc_advance(i_pc_advance),
	.i_pc_down(i_pc_down), .i_pc_load(i_pc_load), .o_program_counter(o_program_counter),
	.o_pc_vector_area(o_pc_vector_area), .o_pc_ivt(o_pc_ivt), .i_prog_data(i_prog_data),
	.o_prog_lo_word(o_prog_lo_word), .o_prog_hi_word(o_prog_hi_word), .o_cfg_done(o_cfg_done),
	.i_rd_req(i_rd_req), .i_rd_byte(i_rd_byte), .o_rd_effective_address(o_rd_effective_address),
	.o_rd_view(o_rd_view), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_wr_req(i_wr_req),
	.i_wr_byte(i_wr_byte), .i_wr_effective_address(i_wr_effective_address), .o_addr_trap(o_addr_trap),
	.o_addr_err(o_addr_err), .i_addr_err_clr(i_addr_err_clr));

// [tb/mad_prog_mem.sv]
// Program memory model answering the fetch address in the same cycle
`timescale 1ns/1ps
module mad_prog_mem
	import mad_pkg::*;
#(
	parameter logic [23:0] CFG_LO = CFG_LO_44K, // Config low word address
	parameter logic [23:0] CFG_A  = 24'h00A55A, // Config low word
	parameter logic [23:0] CFG_B  = 24'h003CC3  // Config high word
) (
	input  wire logic [23:0] i_addr, // Fetch address
	output logic      [23:0] o_data  // Instruction
);
	always_comb begin
		case (i_addr)
			24'h000000:          o_data = 24'h040000; // Jump at reset address
			24'h000002:          o_data = 24'h000200; // Start of user code
			CFG_LO:              o_data = CFG_A;
			CFG_LO + CFG_HI_OFS: o_data = CFG_B;
			default:             o_data = {~i_addr[7:0], i_addr[15:0]}; // Top byte is the inverted low address byte
		endcase
	end
endmodule : mad_prog_mem

// [tb/mad_decode_test.sv]
// Self-checking bench for the memory address decode block
`timescale 1ns/1ps
module mad_decode_test;
	import mad_pkg::*;
	// ------------------------------------------------------------
	// Signals and rows
	// ------------------------------------------------------------
	logic i_clk, i_sys_rst, i_pc_advance, i_pc_down, i_pc_load, i_rd_req, i_rd_byte, i_rd_direct, i_rd_move;
	logic i_rd_postinc, i_wr_req, i_wr_byte, i_wr_postinc, i_wreg_byte_load, i_addr_err_clr;
	logic o_pc_vector_area, o_pc_ivt, o_pc_aivt, o_cfg_done, o_rd_view, o_rd_valid, o_addr_trap, o_addr_err;
	logic [23:0] i_pc_target, o_program_counter, o_prog_addr, i_prog_data;
	logic [15:0] o_prog_lo_word, o_prog_hi_word, o_cfg_reg_a, o_cfg_reg_b, i_rd_direct_addr, o_rd_data;
	logic [15:0] i_source_pointer_register, o_rd_effective_address, o_rd_pointer_nxt, i_wr_effective_address;
	logic [15:0] i_wr_data, o_wr_pointer_nxt, i_wreg_value, o_wreg_result;
	logic [7:0]  i_wreg_byte;
	mad_ext_t    i_ext_op;
	int          failures;
	int          n_compared;

	typedef struct packed {
		logic [15:0] wa;
		logic        wb;
		logic [15:0] wd;
		logic [15:0] ra;
		logic        rb;
		logic [15:0] ex;
	} mad_row_t;
	// Write address, size, data; read address, size, expected data
	mad_row_t rows [6] = '{
		'{16'h0100, 1'h0, 16'h1234, 16'h0100, 1'h0, 16'h1234},
		'{16'h0101, 1'h1, 16'h00AB, 16'h0100, 1'h0, 16'hAB34},
		'{16'h0100, 1'h1, 16'h00CD, 16'h0100, 1'h1, 16'h00CD},
		'{16'h1FFE, 1'h0, 16'hBEEF, 16'h1FFF, 1'h1, 16'h00BE},
		'{16'h2000, 1'h0, 16'h5555, 16'h2000, 1'h0, 16'h0000},
		'{16'h0102, 1'h0, 16'h0F0F, 16'h0102, 1'h0, 16'h0F0F}};

	mad_decode #(.PROG_SIZE(MAD_SZ_44K), .CFG_W(16)) dut (.*);
	mad_prog_mem u_mem (.i_addr(o_prog_addr), .o_data(i_prog_data));

	initial begin
		i_clk = 1'h0;
		forever #50 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic stop_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// Both requests are dropped together for one cycle so no signal is driven twice at once
	task automatic rel;
		i_rd_req = 1'h0;
		i_wr_req = 1'h0;
		@(negedge i_clk);
	endtask : rel

	task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
		i_wr_effective_address = a;
		i_wr_byte = b;
		i_wr_data = d;
		i_wr_req = 1'h1;
		@(negedge i_clk);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic b);
		i_source_pointer_register = a;
		i_rd_byte = b;
		i_rd_req = 1'h1;
		@(negedge i_clk);
	endtask : rd

	task automatic ext(input logic [15:0] v, input logic ld, input mad_ext_t op, input logic [15:0] ex);
		i_wreg_value = v;
		i_wreg_byte_load = ld;
		i_wreg_byte = 8'hAB;
		i_ext_op = op;
		@(negedge i_clk);
		chk("wreg", o_wreg_result, ex);
	endtask : ext

	task automatic reset_run;
		i_sys_rst = 1'h1;
		repeat (12) @(negedge i_clk);
		chk("pc_rst", o_program_counter, 24'h000000);
		chk("cfg_addr", o_prog_addr, CFG_LO_44K);
		chk("done_rst", o_cfg_done, 1'h0);
		chk("err_rst", o_addr_err, 1'h0);
		i_sys_rst = 1'h0;
		repeat (2) @(negedge i_clk);
		chk("done", o_cfg_done, 1'h1);
		chk("cfg_a", o_cfg_reg_a, 16'h5A3C);
		chk("cfg_b", o_cfg_reg_b, 16'hC3A5);
		$display("test reset ended");
	endtask : reset_run

	initial begin
		repeat (1000) @(posedge i_clk);
		failures++;
		stop_test;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_pc_advance, i_pc_down, i_pc_load, i_rd_req, i_rd_byte, i_rd_direct, i_rd_move, i_rd_postinc} = '0;
		{i_wr_req, i_wr_byte, i_wr_postinc, i_wreg_byte_load, i_addr_err_clr, i_pc_target} = '0;
		{i_rd_direct_addr, i_source_pointer_register, i_wr_effective_address, i_wr_data, i_wreg_value} = '0;
		i_wreg_byte = 8'h00;
		i_ext_op = MAD_EXT_NONE;
		failures = 0;
		n_compared = 0;
		reset_run;
		foreach (rows[k]) begin
			wr(rows[k].wa, rows[k].wb, rows[k].wd);
			rel;
			rd(rows[k].ra, rows[k].rb);
			chk("rd_data", o_rd_data, rows[k].ex);
			chk("rd_valid", o_rd_valid, 1'h1);
			rel;
		end
		$display("test rows ended");
		wr(16'h0103, 1'h0, 16'h1111);
		chk("trap_wr", o_addr_trap, 1'h1);
		rel;
		chk("err_wr", o_addr_err, 1'h1);
		rd(16'h0102, 1'h0);
		chk("suppressed", o_rd_data, 16'h0F0F);
		rel;
		i_addr_err_clr = 1'h1;
		@(negedge i_clk);
		i_addr_err_clr = 1'h0;
		chk("err_clr", o_addr_err, 1'h0);
		rd(16'h0101, 1'h0);
		chk("trap_rd", o_addr_trap, 1'h1);
		chk("rd_done", o_rd_valid, 1'h1);
		rel;
		$display("test misaligned ended");
		i_rd_postinc = 1'h1;
		i_wr_postinc = 1'h1;
		for (int b = 0; b < 2; b++) begin
			rd(16'h00FE, b[0]);
			chk("rd_ptr", o_rd_pointer_nxt, b[0] ? 16'h00FF : 16'h0100);
			rel;
			wr(16'h0010, b[0], 16'h0000);
			chk("wr_ptr", o_wr_pointer_nxt, b[0] ? 16'h0011 : 16'h0012);
			rel;
		end
		i_rd_postinc = 1'h0;
		i_wr_postinc = 1'h0;
		i_rd_direct = 1'h1;
		i_rd_direct_addr = 16'hE100;
		rd(16'h0000, 1'h0);
		chk("near_ea", o_rd_effective_address, 16'h0100);
		chk("near_data", o_rd_data, 16'hABCD);
		rel;
		i_rd_move = 1'h1;
		rd(16'h0000, 1'h0);
		chk("move_ea", o_rd_effective_address, 16'hE100);
		chk("view", o_rd_view, 1'h1);
		rel;
		i_rd_direct = 1'h0;
		i_rd_move = 1'h0;
		$display("test addressing ended");
		i_pc_target = 24'h000101;
		i_pc_load = 1'h1;
		i_pc_advance = 1'h1;
		@(negedge i_clk);
		chk("pc_load", o_program_counter, 24'h000100);
		chk("aivt", o_pc_aivt, 1'h1);
		i_pc_load = 1'h0;
		@(negedge i_clk);
		chk("pc_up", o_program_counter, 24'h000102);
		i_pc_down = 1'h1;
		repeat (2) @(negedge i_clk);
		chk("pc_down", o_program_counter, 24'h0000FE);
		chk("ivt", o_pc_ivt, 1'h1);
		chk("vec", o_pc_vector_area, 1'h1);
		i_pc_target = 24'h000200;
		i_pc_load = 1'h1;
		i_pc_advance = 1'h0;
		i_pc_down = 1'h0;
		@(negedge i_clk);
		chk("user", o_pc_vector_area, 1'h0);
		chk("lo_word", o_prog_lo_word, 16'h0200);
		chk("hi_word", o_prog_hi_word, 16'h00FF);
		i_pc_load = 1'h0;
		$display("test program side ended");
		ext(16'h1234, 1'h1, MAD_EXT_NONE, 16'h12AB);
		ext(16'h0080, 1'h0, MAD_EXT_SIGN, 16'hFF80);
		ext(16'h7F7F, 1'h0, MAD_EXT_SIGN, 16'h007F);
		ext(16'hAB80, 1'h0, MAD_EXT_ZERO, 16'h0080);
		$display("test working register ended");
		reset_run;
		stop_test;
	end
endmodule : mad_decode_test
